// ### spi_master_slave_port.v
// four-wire full-duplex serial port, master or slave, with Avalon-MM register access
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
// Functional notes
// - master clock from sysclk/4,/16,/64, sub, timer/2
// - code 101 slave, 110/111 disable port
// - enable bit cleared releases all four lines
// - early deselect in slave sets incomplete and done
// - software incomplete write never sets done
// - polarity 0 idles clock high, 1 low
// - capture edge from polarity and edge bits
// - shift order bit: 0 LSB first, 1 MSB
// - select enable 0 floats select pin, unused
// - data write while busy ignored, collision flag
// - done flag set by hardware, software clears
// - master data write starts full-duplex transfer
// - slave shifts data register on master clocks
// - master makes clock, slave never starts transfer
// - all data passes the 8-bit shift register
// - unimplemented control bits read as zero
// - slave without select enable ignores select pin
// - enabled: output high except slave without select enable, master clock at idle
`include "spi_port_regs.vh"

module spi_master_slave_port (
  input wire MCLK_I,
  input wire RST_I,
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  output reg [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O,
  input wire SUB_CLOCK_I,
  input wire TIMER_MATCH_I,
  input wire SERIAL_IN_PIN_I,
  output reg SERIAL_OUT_PIN_O,
  output wire SERIAL_OUT_PIN_OE_O,
  input wire SERIAL_CLOCK_PIN_I,
  output reg SERIAL_CLOCK_PIN_O,
  output wire SERIAL_CLOCK_PIN_OE_O,
  input wire SLAVE_SELECT_PIN_N_I,
  output reg SLAVE_SELECT_PIN_N_O,
  output wire SLAVE_SELECT_PIN_OE_O,
  output wire PORT_ACTIVE_O,
  output wire TRANSFER_FLAG_O
);

  reg ack_ff;
  reg [2:0] mode_ff;
  reg en_ff;
  reg icf_ff;
  reg pol_ff;
  reg edg_ff;
  reg msb_ff;
  reg csen_ff;
  reg wcol_ff;
  reg trf_ff;
  reg [7:0] sr_ff;
  reg cap_ff;
  reg [4:0] cnt_ff;
  reg busy_ff;
  reg [5:0] div_ff;
  reg sub_s1_ff, sub_s2_ff, sub_s3_ff;
  reg sck_s1_ff, sck_s2_ff, sck_s3_ff;
  reg ss_s1_ff, ss_s2_ff, ss_s3_ff;
  reg sdi_s1_ff, sdi_s2_ff;

  reg [2:0] nxt_mode;
  reg nxt_en, nxt_icf, nxt_pol, nxt_edg, nxt_msb, nxt_csen, nxt_wcol, nxt_trf;
  reg [7:0] nxt_sr;
  reg [4:0] nxt_cnt;
  reg nxt_busy;
  reg [5:0] half;
  reg tick;
  reg [31:0] rd_word;

  wire req = AVS_READ_I | AVS_WRITE_I;
  wire wr_acc = AVS_WRITE_I & ack_ff;
  wire rd_acc = AVS_READ_I & ~ack_ff;
  wire wr_mode = wr_acc & (AVS_ADDRESS_I == `OFS_MODE_CTRL);
  wire wr_fmt = wr_acc & (AVS_ADDRESS_I == `OFS_FORMAT_CTRL);
  wire wr_data = wr_acc & (AVS_ADDRESS_I == `OFS_SHIFT_DATA);

  // one wait state per access: the request is seen, answered on the next edge
  assign AVS_WAITREQUEST_O = req & ~ack_ff;

  wire is_master = (mode_ff <= `MODE_TIMER);
  wire is_slave = (mode_ff == `MODE_SLAVE);
  wire active = en_ff & (is_master | is_slave);
  wire idle_lvl = ~pol_ff;

  // slave is selected by the pin only when the select function is on
  wire slave_sel = csen_ff ? ~ss_s2_ff : 1'b1;
  wire sck_edge = sck_s2_ff ^ sck_s3_ff;
  wire sub_edge = sub_s2_ff ^ sub_s3_ff;

  // every half-period source yields one serial clock edge per tick
  always @* begin
    half = `HALF_DIV4;
    tick = 1'b0;
    if (mode_ff == `MODE_DIV4) begin
      half = `HALF_DIV4;
      tick = (div_ff == half);
    end else if (mode_ff == `MODE_DIV16) begin
      half = `HALF_DIV16;
      tick = (div_ff == half);
    end else if (mode_ff == `MODE_DIV64) begin
      half = `HALF_DIV64;
      tick = (div_ff == half);
    end else if (mode_ff == `MODE_SUB) begin
      tick = sub_edge;
    end else if (mode_ff == `MODE_TIMER) begin
      tick = TIMER_MATCH_I;
    end
  end

  wire master_edge = active & is_master & busy_ff & tick;
  wire slave_edge = active & is_slave & slave_sel & sck_edge;
  wire edge_ev = master_edge | slave_edge;
  wire [4:0] edge_num = cnt_ff + `EDGE_FIRST;
  wire lead = edge_num[0];
  // edge bit set captures on the leading edge, clear on the trailing edge
  wire capture = edge_ev & (edg_ff ? lead : ~lead);
  wire done = edge_ev & (edge_num == `EDGE_LAST);
  wire shift = edge_ev & (edg_ff ? ~lead : ((lead & (edge_num != `EDGE_FIRST)) | done));
  wire in_bit = capture ? sdi_s2_ff : cap_ff;
  wire out_bit = msb_ff ? sr_ff[7] : sr_ff[0];
  wire busy_any = busy_ff | (cnt_ff != 5'h00);
  // select released by the master mid-byte
  wire abort = active & is_slave & csen_ff & ss_s2_ff & ~ss_s3_ff & (cnt_ff != 5'h00);
  wire start = wr_data & ~busy_any & active & is_master;

  always @* begin
    nxt_mode = mode_ff;
    nxt_en = en_ff;
    nxt_icf = icf_ff;
    nxt_pol = pol_ff;
    nxt_edg = edg_ff;
    nxt_msb = msb_ff;
    nxt_csen = csen_ff;
    nxt_wcol = wcol_ff;
    nxt_trf = trf_ff;
    nxt_sr = sr_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    if (wr_mode) begin
      nxt_mode = AVS_WRITEDATA_I[`MODE_MSB:`MODE_LSB];
      nxt_en = AVS_WRITEDATA_I[`BIT_PORT_ENABLE];
      nxt_icf = AVS_WRITEDATA_I[`BIT_INCOMPLETE];
    end
    if (wr_fmt) begin
      nxt_pol = AVS_WRITEDATA_I[`BIT_CLOCK_POLARITY];
      nxt_edg = AVS_WRITEDATA_I[`BIT_CAPTURE_EDGE];
      nxt_msb = AVS_WRITEDATA_I[`BIT_SHIFT_ORDER];
      nxt_csen = AVS_WRITEDATA_I[`BIT_SELECT_ENABLE];
      nxt_wcol = AVS_WRITEDATA_I[`BIT_WRITE_COLLISION];
      nxt_trf = AVS_WRITEDATA_I[`BIT_TRANSFER_DONE];
    end
    if (wr_data & ~busy_any) begin
      nxt_sr = AVS_WRITEDATA_I[7:0];
    end
    if (shift) begin
      if (msb_ff) begin
        nxt_sr = {sr_ff[6:0], in_bit};
      end else begin
        nxt_sr = {in_bit, sr_ff[7:1]};
      end
    end
    if (start) begin
      nxt_busy = 1'b1;
      nxt_cnt = 5'h00;
    end
    if (edge_ev) begin
      nxt_cnt = edge_num;
    end
    if (done | abort | ~active | (is_slave & ~slave_sel)) begin
      nxt_cnt = 5'h00;
      nxt_busy = 1'b0;
    end
    // hardware sets win over a software clear in the same cycle
    if (wr_data & busy_any) begin
      nxt_wcol = 1'b1;
    end
    if (abort) begin
      nxt_icf = 1'b1;
    end
    if (done | abort) begin
      nxt_trf = 1'b1;
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    if (AVS_ADDRESS_I == `OFS_MODE_CTRL) begin
      rd_word[`MODE_MSB:`MODE_LSB] = mode_ff;
      rd_word[`BIT_PORT_ENABLE] = en_ff;
      rd_word[`BIT_INCOMPLETE] = icf_ff;
    end else if (AVS_ADDRESS_I == `OFS_FORMAT_CTRL) begin
      rd_word[`BIT_CLOCK_POLARITY] = pol_ff;
      rd_word[`BIT_CAPTURE_EDGE] = edg_ff;
      rd_word[`BIT_SHIFT_ORDER] = msb_ff;
      rd_word[`BIT_SELECT_ENABLE] = csen_ff;
      rd_word[`BIT_WRITE_COLLISION] = wcol_ff;
      rd_word[`BIT_TRANSFER_DONE] = trf_ff;
    end else if (AVS_ADDRESS_I == `OFS_SHIFT_DATA) begin
      rd_word[7:0] = sr_ff;
    end
  end

  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_ff <= 1'b0;
      AVS_READDATA_O <= 32'h00000000;
      mode_ff <= `RST_MODE;
      en_ff <= `RST_BIT;
      icf_ff <= `RST_BIT;
      pol_ff <= `RST_BIT;
      edg_ff <= `RST_BIT;
      msb_ff <= `RST_BIT;
      csen_ff <= `RST_BIT;
      wcol_ff <= `RST_BIT;
      trf_ff <= `RST_BIT;
      sr_ff <= `RST_DATA;
      cap_ff <= 1'b0;
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (rd_acc) begin
        AVS_READDATA_O <= rd_word;
      end
      mode_ff <= nxt_mode;
      en_ff <= nxt_en;
      icf_ff <= nxt_icf;
      pol_ff <= nxt_pol;
      edg_ff <= nxt_edg;
      msb_ff <= nxt_msb;
      csen_ff <= nxt_csen;
      wcol_ff <= nxt_wcol;
      trf_ff <= nxt_trf;
      sr_ff <= nxt_sr;
      if (capture) begin
        cap_ff <= sdi_s2_ff;
      end
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  // synchronisers; the first stage feeds only the second
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      sub_s1_ff <= 1'b0;
      sub_s2_ff <= 1'b0;
      sub_s3_ff <= 1'b0;
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_s3_ff <= 1'b0;
      ss_s1_ff <= 1'b1;
      ss_s2_ff <= 1'b1;
      ss_s3_ff <= 1'b1;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
    end else begin
      sub_s1_ff <= SUB_CLOCK_I;
      sub_s2_ff <= sub_s1_ff;
      sub_s3_ff <= sub_s2_ff;
      sck_s1_ff <= SERIAL_CLOCK_PIN_I;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      ss_s1_ff <= SLAVE_SELECT_PIN_N_I;
      ss_s2_ff <= ss_s1_ff;
      ss_s3_ff <= ss_s2_ff;
      sdi_s1_ff <= SERIAL_IN_PIN_I;
      sdi_s2_ff <= sdi_s1_ff;
    end
  end

  // divider restarts with each transfer so the first edge is a full half period away
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_ff <= 6'h00;
    end else if (start | ~busy_ff | tick) begin
      div_ff <= 6'h00;
    end else begin
      div_ff <= div_ff + 6'h01;
    end
  end

  // pin drivers; a disabled port releases every line
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      SERIAL_OUT_PIN_O <= 1'b1;
      SERIAL_CLOCK_PIN_O <= 1'b1;
      SLAVE_SELECT_PIN_N_O <= 1'b1;
    end else begin
      if (active & (is_master ? busy_ff : slave_sel)) begin
        SERIAL_OUT_PIN_O <= out_bit;
      end else begin
        SERIAL_OUT_PIN_O <= 1'b1;
      end
      if (master_edge) begin
        SERIAL_CLOCK_PIN_O <= ~SERIAL_CLOCK_PIN_O;
      end else if (~busy_ff) begin
        SERIAL_CLOCK_PIN_O <= idle_lvl;
      end
      // select goes low on start, a half period before the first clock edge
      SLAVE_SELECT_PIN_N_O <= ~(nxt_busy & is_master);
    end
  end

  assign SERIAL_OUT_PIN_OE_O = active;
  assign SERIAL_CLOCK_PIN_OE_O = active & is_master;
  assign SLAVE_SELECT_PIN_OE_O = active & is_master & csen_ff;
  assign PORT_ACTIVE_O = active;
  assign TRANSFER_FLAG_O = trf_ff;

endmodule

// ### spi_master_slave_port_bench.sv
// self-checking bench for the serial port
`timescale 1ns/100ps
module spi_master_slave_port_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] adr = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg sck = 1'b1;
  reg ssn = 1'b1;
  reg tm = 1'b0;
  reg [31:0] q = 32'h0;
  reg [23:0] rows [0:5];
  wire [31:0] rdat;
  wire [7:0] rx_byte;
  wire wt, sdi, sdo, sdo_oe, sck_o, sck_oe, ss_o, ss_oe, act, flag;
  integer failures = 0;
  integer total_checks = 0;
  integer i;
  integer n;
  always #5 clk = ~clk;
  spi_master_slave_port u_spi_master_slave_port (.MCLK_I(clk), .RST_I(rst),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .SUB_CLOCK_I(1'b0),
    .TIMER_MATCH_I(tm), .SERIAL_IN_PIN_I(sdi), .SERIAL_OUT_PIN_O(sdo),
    .SERIAL_OUT_PIN_OE_O(sdo_oe), .SERIAL_CLOCK_PIN_I(sck), .SERIAL_CLOCK_PIN_O(sck_o),
    .SERIAL_CLOCK_PIN_OE_O(sck_oe), .SLAVE_SELECT_PIN_N_I(ssn),
    .SLAVE_SELECT_PIN_N_O(ss_o), .SLAVE_SELECT_PIN_OE_O(ss_oe),
    .PORT_ACTIVE_O(act), .TRANSFER_FLAG_O(flag));
  spi_slave_model u_spi_slave_model (.cpol_i(1'b0), .sck_i(sck_o), .ss_n_i(ss_o),
    .sdo_i(sdo), .sdi_o(sdi), .rx_o(rx_byte));
  task final_report;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one bus cycle; called right after a rising edge, leaves one idle edge behind
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      adr <= a;
      wd <= {24'h0, d};
      rd <= ~w;
      wr <= w;
      n = 0;
      @(posedge clk);
      while (wt !== 1'b0 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      q = rdat;
      if (n >= 50) begin
        failures = failures + 1;
        final_report;
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial begin
    rows[0] = 24'h00ffe3;
    rows[1] = 24'h44ff3f;
    rows[2] = 24'h440000;
    rows[3] = 24'h04e100;
    rows[4] = 24'hccff00;
    rows[5] = 24'h885a5a;
    for (i = 0; i < 16; i = i + 1) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 4'h0, 8'h00);
    check(q, 32'he0, "mode_rst");
    bus(1'b0, 4'h4, 8'h00);
    check(q, 32'h00, "fmt_rst");
    // write one place, read back possibly another (incomplete write, unmapped)
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b1, rows[i][23:20], rows[i][15:8]);
      bus(1'b0, rows[i][19:16], 8'h00);
      check(q, {24'h0, rows[i][7:0]}, "row");
    end
    // incomplete flag was set by software above, complete must stay low
    check(flag, 1'b0, "icf_sw");
    bus(1'b1, 4'h4, 8'h1c);
    bus(1'b1, 4'h0, 8'h22);
    check(sck_o, 1'b1, "sck_idle");
    check({act, sdo_oe, sck_oe, ss_oe}, 4'hf, "oe_on");
    bus(1'b1, 4'h8, 8'h3c);
    bus(1'b1, 4'h8, 8'h99);
    n = 0;
    while (flag !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n = n + 1;
    end
    check(n < 2000, 1'b1, "done");
    check(rx_byte, 8'h3c, "tx_byte");
    bus(1'b0, 4'h8, 8'h00);
    check(q, 32'ha5, "rx_byte");
    bus(1'b0, 4'h4, 8'h00);
    check(q, 32'h1f, "coll");
    // timer-paced master, lsb first; pulses 4 cycles apart keep the sync lag covered
    bus(1'b1, 4'h4, 8'h14);
    bus(1'b1, 4'h0, 8'h82);
    bus(1'b1, 4'h8, 8'h01);
    n = 0;
    while (flag !== 1'b1 && n < 2000) begin
      @(posedge clk);
      tm <= (n % 4 == 3);
      n = n + 1;
    end
    tm <= 1'b0;
    check(n < 2000, 1'b1, "tm_done");
    check(rx_byte, 8'h80, "lsb_tx");
    bus(1'b0, 4'h8, 8'h00);
    check(q, 32'ha5, "lsb_rx");
    // polarity 1 and flags cleared by software
    bus(1'b1, 4'h4, 8'h3c);
    @(posedge clk);
    check({sck_o, flag}, 2'b00, "pol1");
    // slave deselected mid-byte
    sck <= 1'b0;
    bus(1'b1, 4'h0, 8'ha2);
    ssn <= 1'b0;
    for (i = 0; i < 30; i = i + 1) begin
      @(posedge clk);
      if (i % 6 == 5)
        sck <= ~sck;
    end
    ssn <= 1'b1;
    for (i = 0; i < 10; i = i + 1) @(posedge clk);
    bus(1'b0, 4'h0, 8'h00);
    check(q, 32'ha3, "icf");
    bus(1'b0, 4'h4, 8'h00);
    check(q, 32'h3d, "icf_trf");
    bus(1'b1, 4'h0, 8'hc2);
    check({act, sdo_oe, sck_oe, ss_oe}, 4'h0, "mode_off");
    bus(1'b1, 4'h0, 8'h00);
    check({act, sdo_oe, sck_oe, ss_oe}, 4'h0, "en_off");
    final_report;
  end
endmodule

// ### spi_port_monitor.sv
// concurrent checks on the serial port top-level pins
`timescale 1ns/100ps
module spi_port_monitor (
  input wire MCLK_I,
  input wire RST_I,
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire AVS_WAITREQUEST_O,
  input wire SERIAL_OUT_PIN_O,
  input wire SERIAL_OUT_PIN_OE_O,
  input wire SERIAL_CLOCK_PIN_O,
  input wire SERIAL_CLOCK_PIN_OE_O,
  input wire SLAVE_SELECT_PIN_N_O,
  input wire SLAVE_SELECT_PIN_OE_O,
  input wire PORT_ACTIVE_O,
  input wire TRANSFER_FLAG_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  logic [4:0] edge_cnt_ff;
  logic sck_q_ff;
  wire acc = (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;
  wire toggled = SERIAL_CLOCK_PIN_O != sck_q_ff;
  // counts master clock edges inside one select window
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      edge_cnt_ff <= 5'h00;
      sck_q_ff <= 1'b1;
    end else begin
      sck_q_ff <= SERIAL_CLOCK_PIN_O;
      edge_cnt_ff <= SLAVE_SELECT_PIN_N_O ? 5'h00 : edge_cnt_ff + {4'h0, toggled};
    end
  end
  property p_off;
    !PORT_ACTIVE_O |-> !SERIAL_OUT_PIN_OE_O && !SERIAL_CLOCK_PIN_OE_O && !SLAVE_SELECT_PIN_OE_O;
  endproperty
  a_off: assert property (p_off) else $error("pins driven while port off");
  property p_oe;
    SERIAL_CLOCK_PIN_OE_O |-> SERIAL_OUT_PIN_OE_O && PORT_ACTIVE_O;
  endproperty
  a_oe: assert property (p_oe) else $error("master clock driven without data out");
  property p_sdo_high;
    SERIAL_CLOCK_PIN_OE_O && SLAVE_SELECT_PIN_N_O && $past(SLAVE_SELECT_PIN_N_O)
      |-> SERIAL_OUT_PIN_O;
  endproperty
  a_sdo_high: assert property (p_sdo_high) else $error("data out not high when idle");
  property p_sck_still;
    SERIAL_CLOCK_PIN_OE_O && SLAVE_SELECT_PIN_N_O && $past(SLAVE_SELECT_PIN_N_O)
      && !$past(AVS_WRITE_I) && !$past(AVS_WRITE_I, 2) |-> $stable(SERIAL_CLOCK_PIN_O);
  endproperty
  a_sck_still: assert property (p_sck_still) else $error("clock moved while deselected");
  property p_start;
    acc && AVS_WRITE_I && AVS_ADDRESS_I == 4'h8 && SERIAL_CLOCK_PIN_OE_O
      && SLAVE_SELECT_PIN_N_O |=> ##[0:1] !SLAVE_SELECT_PIN_N_O;
  endproperty
  a_start: assert property (p_start) else $error("data write did not start transfer");
  property p_eight;
    $rose(SLAVE_SELECT_PIN_N_O) |-> edge_cnt_ff + {4'h0, toggled} == 5'h10;
  endproperty
  a_eight: assert property (p_eight) else $error("transfer clock edge count wrong");
  property p_done;
    $rose(SLAVE_SELECT_PIN_N_O) && SERIAL_CLOCK_PIN_OE_O |-> ##[0:2] TRANSFER_FLAG_O;
  endproperty
  a_done: assert property (p_done) else $error("complete flag not set");
  property p_hold;
    TRANSFER_FLAG_O && !(acc && AVS_WRITE_I && AVS_ADDRESS_I == 4'h4) |=> TRANSFER_FLAG_O;
  endproperty
  a_hold: assert property (p_hold) else $error("complete flag dropped by itself");
  property p_upper;
    acc && AVS_READ_I |-> AVS_READDATA_O[31:8] == 24'h0
      && (AVS_ADDRESS_I != 4'hc || AVS_READDATA_O == 32'h0);
  endproperty
  a_upper: assert property (p_upper) else $error("unused read bits not zero");
endmodule
bind spi_master_slave_port spi_port_monitor u_spi_port_monitor (
  .MCLK_I(MCLK_I),
  .RST_I(RST_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O),
  .SERIAL_OUT_PIN_OE_O(SERIAL_OUT_PIN_OE_O),
  .SERIAL_CLOCK_PIN_O(SERIAL_CLOCK_PIN_O),
  .SERIAL_CLOCK_PIN_OE_O(SERIAL_CLOCK_PIN_OE_O),
  .SLAVE_SELECT_PIN_N_O(SLAVE_SELECT_PIN_N_O),
  .SLAVE_SELECT_PIN_OE_O(SLAVE_SELECT_PIN_OE_O),
  .PORT_ACTIVE_O(PORT_ACTIVE_O),
  .TRANSFER_FLAG_O(TRANSFER_FLAG_O)
);

// ### spi_port_regs.vh
// register map, field positions, reset values and timing constants of the serial port
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

`define OFS_MODE_CTRL 4'h0
`define OFS_FORMAT_CTRL 4'h4
`define OFS_SHIFT_DATA 4'h8

`define MODE_LSB 5
`define MODE_MSB 7
`define BIT_PORT_ENABLE 1
`define BIT_INCOMPLETE 0

`define BIT_CLOCK_POLARITY 5
`define BIT_CAPTURE_EDGE 4
`define BIT_SHIFT_ORDER 3
`define BIT_SELECT_ENABLE 2
`define BIT_WRITE_COLLISION 1
`define BIT_TRANSFER_DONE 0

`define RST_MODE 3'h7
`define RST_BIT 1'h0
`define RST_DATA 8'h00

`define MODE_DIV4 3'h0
`define MODE_DIV16 3'h1
`define MODE_DIV64 3'h2
`define MODE_SUB 3'h3
`define MODE_TIMER 3'h4
`define MODE_SLAVE 3'h5

`define HALF_DIV4 6'h01
`define HALF_DIV16 6'h07
`define HALF_DIV64 6'h1f

`define EDGE_FIRST 5'h01
`define EDGE_LAST 5'h10

`endif

// ### spi_slave_model.sv
// external serial slave answering the master with a fixed byte
`timescale 1ns/100ps
module spi_slave_model #(parameter [7:0] TX = 8'ha5) (
  input wire cpol_i,
  input wire sck_i,
  input wire ss_n_i,
  input wire sdo_i,
  output reg sdi_o = 1'b0,
  output reg [7:0] rx_o = 8'h00
);
  reg [7:0] tx_ff = 8'h00;
  // first bit must be on the line before the first clock edge
  always @(negedge ss_n_i) begin
    tx_ff = TX;
    sdi_o = TX[7];
  end
  // released line never shows the last bit
  always @(posedge ss_n_i) sdi_o = ~sdi_o;
  // only follows the master clock, never makes one
  always @(sck_i) begin
    if (!ss_n_i && sck_i == cpol_i) begin
      rx_o = {rx_o[6:0], sdo_i};
    end else if (!ss_n_i) begin
      tx_ff = {tx_ff[6:0], 1'b0};
      sdi_o = tx_ff[7];
    end
  end
endmodule
